/* core/spb_dev_end.sv */
/*
 * Device end of the serial programming link: frame receiver, core
 * instruction subset, table pointer, memory_write_control, bulk erase
 * control registers, self-timed bulk erase and code protection.
 * Assumes the host keeps the data line low while an erase runs.
 */
// The implementer's own choice: the address-and-strobe port.

module spb_dev_end #(
    parameter bit BIG_MAP = 1'h0,
    parameter int ERASE_CYC = spb_pkg::ERASE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    spb_link_if.dev lk,
    input wire logic [spb_pkg::NUNITS-1:0] protect_set,
    output logic mem_wr,
    output logic [21:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic row_erase,
    output logic prog_start,
    output logic erase_busy,
    output logic [spb_pkg::NUNITS-1:0] erase_mask,
    output logic [spb_pkg::NUNITS-1:0] protect
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function automatic logic [spb_pkg::NUNITS-1:0] unit_of(
        input logic [21:0] a);
        logic [spb_pkg::NUNITS-1:0] u;
        u = '0;
        if (BIG_MAP) begin
            if (a <= spb_pkg::BIG_BOOT_TOP) begin
                u = 8'h01 << spb_pkg::U_BOOT;
            end else if (a <= spb_pkg::BIG_TOP) begin
                u = 8'h01 << (spb_pkg::U_BLK0 +
                    int'(a[spb_pkg::BIG_BLK_LSB +: 2]));
            end
        end else begin
            if (a <= spb_pkg::SMALL_BOOT_TOP) begin
                u = 8'h01 << spb_pkg::U_BOOT;
            end else if (a <= spb_pkg::SMALL_TOP) begin
                u = 8'h01 << (spb_pkg::U_BLK0 +
                    int'(a[spb_pkg::SMALL_BLK_LSB]));
            end
        end
        return u;
    endfunction

    function automatic logic [spb_pkg::NUNITS-1:0] erase_units(
        input logic [15:0] v);
        logic [spb_pkg::NUNITS-1:0] u;
        u = '0;
        case (v)
            spb_pkg::ER_CHIP: u = '1;
            spb_pkg::ER_USER_ID: u = 8'h01 << spb_pkg::U_ID;
            spb_pkg::ER_CFG: u = 8'h01 << spb_pkg::U_CFG;
            spb_pkg::ER_DATA: u = 8'h01 << spb_pkg::U_DATA;
            spb_pkg::ER_BOOT: u = 8'h01 << spb_pkg::U_BOOT;
            spb_pkg::ER_BLK0: u = 8'h01 << spb_pkg::U_BLK0;
            spb_pkg::ER_BLK1: u = 8'h02 << spb_pkg::U_BLK0;
            spb_pkg::ER_BLK2: u = 8'h04 << spb_pkg::U_BLK0;
            spb_pkg::ER_BLK3: u = 8'h08 << spb_pkg::U_BLK0;
            default: u = '0;
        endcase
        return u;
    endfunction

    // ------------------------------------------------------------
    // link pins
    // ------------------------------------------------------------
    logic [1:0] pin_lvl;
    logic [1:0] pin_fall;

    spb_pin_sync #(.W(2)) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_in({lk.dat, lk.sclk}),
        .level_r(pin_lvl),
        .fall_r(pin_fall)
    );

    // device never drives the data line in this block
    assign lk.dev_dat_o = 1'h0;
    assign lk.dev_dat_oe = 1'h0;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [4:0] bit_cnt_r;
    logic [spb_pkg::FRAME_BITS-1:0] sh_r;
    logic [7:0] w_r;
    logic [21:0] tbl_r;
    logic [7:0] mwc_r;
    logic [7:0] be_low_r;
    logic [7:0] be_high_r;
    logic armed_r;
    logic busy_r;
    logic [31:0] ecnt_r;
    logic [spb_pkg::NUNITS-1:0] emask_r;
    logic [spb_pkg::NUNITS-1:0] prot_r;

    // ------------------------------------------------------------
    // frame decode
    // ------------------------------------------------------------
    logic step, at4, done;
    logic [spb_pkg::FRAME_BITS-1:0] frame;
    logic [3:0] cmd, nib_now;
    logic [15:0] pay;
    logic [7:0] op_hi, op_lo;

    // serial execution halts while an erase runs
    assign step = pin_fall[0] && !busy_r;
    assign at4 = step && bit_cnt_r == 5'(spb_pkg::CMD_BITS - 1);
    assign done = step && bit_cnt_r == 5'(spb_pkg::FRAME_BITS - 1);
    assign frame = {pin_lvl[1], sh_r[spb_pkg::FRAME_BITS-1:1]};
    assign nib_now = frame[spb_pkg::FRAME_BITS-1 -: spb_pkg::CMD_BITS];
    assign cmd = frame[spb_pkg::CMD_BITS-1:0];
    assign pay = frame[spb_pkg::FRAME_BITS-1:spb_pkg::CMD_BITS];
    assign op_hi = pay[15:8];
    assign op_lo = pay[7:0];

    // ------------------------------------------------------------
    // core instructions and memory_write_control
    // ------------------------------------------------------------
    logic is_core, movlw, movwf, bsf, bcf;
    logic [7:0] bit_mask, mwc_val;
    logic mwc_we, launch;
    logic [spb_pkg::NUNITS-1:0] tbl_unit;
    logic unprot, region_ok;

    assign is_core = done && cmd == spb_pkg::CMD_CORE;
    assign movlw = is_core && op_hi == spb_pkg::OP_MOVLW;
    assign movwf = is_core && op_hi == spb_pkg::OP_MOVWF;
    assign bsf = is_core && op_lo == spb_pkg::SFR_MWC &&
                 pay[spb_pkg::OPC_NIB_LSB +: 4] == spb_pkg::OP_BSF;
    assign bcf = is_core && op_lo == spb_pkg::SFR_MWC &&
                 pay[spb_pkg::OPC_NIB_LSB +: 4] == spb_pkg::OP_BCF;
    assign bit_mask = 8'h01 << pay[spb_pkg::BIT_IDX_LSB +: 3];
    assign mwc_we = (movwf && op_lo == spb_pkg::SFR_MWC) || bsf || bcf;
    assign mwc_val = movwf ? w_r :
                     (bsf ? (mwc_r | bit_mask) : (mwc_r & ~bit_mask));
    assign region_ok = mwc_r[spb_pkg::REGION_SELECT_BIT] &&
                       !mwc_r[spb_pkg::CONFIG_SPACE_SELECT_BIT];
    assign tbl_unit = unit_of(tbl_r);
    assign unprot = |tbl_unit && !(|(tbl_unit & prot_r));
    // enable must already be set; region taken from the new value
    assign launch = mwc_we && mwc_val[spb_pkg::WRITE_START_BIT] &&
                    mwc_r[spb_pkg::WRITE_ENABLE_BIT] &&
                    mwc_val[spb_pkg::REGION_SELECT_BIT] &&
                    !mwc_val[spb_pkg::CONFIG_SPACE_SELECT_BIT] &&
                    unprot;

    // ------------------------------------------------------------
    // table writes and bulk erase trigger
    // ------------------------------------------------------------
    logic tw, tw2, be_lo_hit, be_hi_hit, code_wr;
    logic erase_go, erase_end;

    assign tw2 = done && cmd == spb_pkg::CMD_TBL_WR_INC2;
    assign tw = tw2 || (done && cmd == spb_pkg::CMD_TBL_WR);
    assign be_lo_hit = tw && tbl_r == spb_pkg::BULK_ERASE_CTRL_LOW;
    assign be_hi_hit = tw && tbl_r == spb_pkg::BULK_ERASE_CTRL_HIGH;
    assign code_wr = tw && region_ok && unprot &&
                     mwc_r[spb_pkg::WRITE_ENABLE_BIT];
    assign erase_go = at4 && armed_r && nib_now == spb_pkg::CMD_CORE;
    assign erase_end = busy_r && ecnt_r == 32'(ERASE_CYC - 1);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst || erase_end) begin
            bit_cnt_r <= '0;
            sh_r <= '0;
        end else if (step) begin
            bit_cnt_r <= done ? 5'h00 : bit_cnt_r + 5'h01;
            sh_r <= frame;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            w_r <= '0;
            mwc_r <= '0;
        end else begin
            if (movlw) begin
                w_r <= op_lo;
            end
            if (mwc_we) begin
                // start bit clears itself after every write, whether or not a sequence starts
                mwc_r <= mwc_val & ~(8'h01 << spb_pkg::WRITE_START_BIT);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tbl_r <= '0;
        end else if (movwf && op_lo == spb_pkg::SFR_TBL_LOW) begin
            tbl_r[7:0] <= w_r;
        end else if (movwf && op_lo == spb_pkg::SFR_TBL_HIGH) begin
            tbl_r[spb_pkg::TBL_HIGH_LSB +: 8] <= w_r;
        end else if (movwf && op_lo == spb_pkg::SFR_TBL_UPPER) begin
            tbl_r[spb_pkg::TBL_UPPER_LSB +: spb_pkg::TBL_UPPER_W] <=
                w_r[spb_pkg::TBL_UPPER_W-1:0];
        end else if (tw2) begin
            tbl_r <= tbl_r + spb_pkg::TBL_STEP;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            be_low_r <= '0;
            be_high_r <= '0;
            armed_r <= 1'h0;
        end else begin
            if (be_lo_hit) begin
                be_low_r <= op_lo;
            end
            if (be_hi_hit) begin
                be_high_r <= op_lo;
            end
            // low byte write is the trigger; next command consumes it
            if (be_lo_hit) begin
                armed_r <= 1'h1;
            end else if (at4) begin
                armed_r <= 1'h0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            busy_r <= 1'h0;
            ecnt_r <= '0;
            emask_r <= '0;
        end else if (erase_go) begin
            busy_r <= 1'h1;
            ecnt_r <= '0;
            emask_r <= erase_units({be_high_r, be_low_r});
        end else if (erase_end) begin
            busy_r <= 1'h0;
        end else if (busy_r) begin
            ecnt_r <= ecnt_r + 32'h1;
        end
    end

    // a protect request in the erase's last cycle wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prot_r <= '0;
        end else begin
            prot_r <= (prot_r & ~(erase_end ? emask_r : '0)) |
                      protect_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mem_wr <= 1'h0;
            mem_addr <= '0;
            mem_wdata <= '0;
            row_erase <= 1'h0;
            prog_start <= 1'h0;
        end else begin
            mem_wr <= code_wr && !be_lo_hit && !be_hi_hit;
            if (code_wr || launch) begin
                mem_addr <= tbl_r;
            end
            if (code_wr) begin
                mem_wdata <= pay;
            end
            row_erase <= launch && mwc_val[spb_pkg::ERASE_SELECT_BIT];
            prog_start <= launch && !mwc_val[spb_pkg::ERASE_SELECT_BIT];
        end
    end

    assign erase_busy = busy_r;
    assign erase_mask = emask_r;
    assign protect = prot_r;
endmodule // spb_dev_end

/* core/spb_host_end.sv */
/*
 * Host end of the programming link: sends one 20-bit frame per
 * command register write made while idle, optionally followed by a hold period with
 * the clock idle and data low. Software port: addr, wdata, wr, rd,
 * rdata one cycle after rd.
 */
module spb_host_end #(
    parameter int HALF_CYC = spb_pkg::LINK_HALF_CYC,
    parameter int HOLD_CYC = spb_pkg::HOLD_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    spb_link_if.host lk
);
    typedef enum logic [1:0] {H_IDLE, H_HIGH, H_LOW, H_HOLD} spb_hstate_t;

    spb_hstate_t state_r;
    logic [spb_pkg::FRAME_BITS-1:0] frame_r;
    logic hold_r;
    logic [4:0] bit_r;
    logic [31:0] cnt_r;
    logic sclk_r;
    logic dat_r;
    logic ovr_r;
    logic [31:0] rdata_r;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic cmd_wr, start, st_rd, half_end, last_bit, hold_end;
    assign cmd_wr = wr && addr == spb_pkg::HREG_CMD;
    assign start = cmd_wr && state_r == H_IDLE;
    assign st_rd = rd && addr == spb_pkg::HREG_STATUS;
    assign half_end = cnt_r == 32'(HALF_CYC - 1);
    assign last_bit = bit_r == 5'(spb_pkg::FRAME_BITS - 1);
    assign hold_end = cnt_r == 32'(HOLD_CYC - 1);

    // ------------------------------------------------------------
    // link sequencer
    // ------------------------------------------------------------
    // data changes with the rising clock; the device samples it at
    // the falling clock half a link period later
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= H_IDLE;
            frame_r <= '0;
            hold_r <= 1'h0;
            bit_r <= '0;
            cnt_r <= '0;
            sclk_r <= 1'h0;
            dat_r <= 1'h0;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            case (state_r)
                H_IDLE: begin
                    if (start) begin
                        frame_r <= wdata[spb_pkg::FRAME_BITS-1:0];
                        hold_r <= wdata[spb_pkg::HCMD_HOLD_BIT];
                        bit_r <= '0;
                        cnt_r <= '0;
                        sclk_r <= 1'h1;
                        dat_r <= wdata[0];
                        state_r <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (half_end) begin
                        sclk_r <= 1'h0;
                        cnt_r <= '0;
                        state_r <= H_LOW;
                    end
                end
                H_LOW: begin
                    if (half_end && last_bit) begin
                        dat_r <= 1'h0;
                        cnt_r <= '0;
                        state_r <= hold_r ? H_HOLD : H_IDLE;
                    end else if (half_end) begin
                        bit_r <= bit_r + 5'h01;
                        sclk_r <= 1'h1;
                        dat_r <= frame_r[bit_r + 5'h01];
                        cnt_r <= '0;
                        state_r <= H_HIGH;
                    end
                end
                H_HOLD: begin
                    dat_r <= 1'h0;
                    if (hold_end) begin
                        state_r <= H_IDLE;
                    end
                end
                default: state_r <= H_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // status
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ovr_r <= 1'h0;
            rdata_r <= '0;
        end else begin
            // a refused write in the read cycle is kept
            if (cmd_wr && state_r != H_IDLE) begin
                ovr_r <= 1'h1;
            end else if (st_rd) begin
                ovr_r <= 1'h0;
            end
            rdata_r <= '0;
            if (st_rd) begin
                rdata_r[spb_pkg::HST_BUSY_BIT] <= state_r != H_IDLE;
                rdata_r[spb_pkg::HST_OVR_BIT] <= ovr_r;
            end
        end
    end

    assign rdata = rdata_r;
    assign lk.sclk = sclk_r;
    assign lk.host_dat_o = dat_r;
    assign lk.host_dat_oe = 1'h1;
endmodule // spb_host_end

/* core/spb_link_if.sv */
/*
 * Two-wire programming link: serial clock from the host and one
 * shared data line. The data level is resolved here from the enables.
 * Assumes the testbench instantiates it and joins both ends.
 */
interface spb_link_if;
    logic sclk;
    logic host_dat_o;
    logic host_dat_oe;
    logic dev_dat_o;
    logic dev_dat_oe;
    logic dat;

    // undriven line reads low
    assign dat = host_dat_oe ? host_dat_o :
                 (dev_dat_oe ? dev_dat_o : 1'h0);

    modport host (output sclk, output host_dat_o, output host_dat_oe,
                  input dat);
    modport dev (input sclk, input dat, output dev_dat_o,
                 output dev_dat_oe);
endinterface : spb_link_if

/* core/spb_pin_sync.sv */
/*
 * Three-stage pin synchroniser with agreement filter and falling-edge
 * pulse. Assumes pins are asynchronous to ref_clk.
 */
module spb_pin_sync #(
    parameter int W = 2
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_r,
    output logic [W-1:0] fall_r
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] agree;
    logic [W-1:0] level_nxt;

    // a change counts once the second and third stages agree
    assign agree = ~(s2_r ^ s3_r);
    assign level_nxt = (s2_r & agree) | (level_r & ~agree);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            level_r <= '0;
            fall_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            level_r <= level_nxt;
            fall_r <= level_r & ~level_nxt;
        end
    end
endmodule // spb_pin_sync

/* core/spb_pkg.sv */
/*
 * Shared constants for the serial programming link: command codes,
 * frame layout, code memory map, erase codes, control bit positions,
 * host register map and timing counts.
 * Assumes a 25 MHz ref_clk on both ends.
 */
package spb_pkg;
    // ------------------------------------------------------------
    // serial frame
    // ------------------------------------------------------------
    localparam int CMD_BITS = 4;
    localparam int PAY_BITS = 16;
    localparam int FRAME_BITS = CMD_BITS + PAY_BITS;
    localparam logic [3:0] CMD_CORE = 4'h0;
    localparam logic [3:0] CMD_TBL_WR = 4'hC;
    localparam logic [3:0] CMD_TBL_WR_INC2 = 4'hD;
    localparam logic [21:0] TBL_STEP = 22'h000002;

    // ------------------------------------------------------------
    // core instructions and special registers
    // ------------------------------------------------------------
    localparam logic [7:0] OP_MOVLW = 8'h0E;
    localparam logic [7:0] OP_MOVWF = 8'h6E;
    localparam logic [3:0] OP_BSF = 4'h8;
    localparam logic [3:0] OP_BCF = 4'h9;
    localparam int OPC_NIB_LSB = 12;
    localparam int BIT_IDX_LSB = 9;
    localparam logic [7:0] SFR_TBL_LOW = 8'hF6;
    localparam logic [7:0] SFR_TBL_HIGH = 8'hF7;
    localparam logic [7:0] SFR_TBL_UPPER = 8'hF8;
    localparam logic [7:0] SFR_MWC = 8'hA6;
    localparam int TBL_HIGH_LSB = 8;
    localparam int TBL_UPPER_LSB = 16;
    localparam int TBL_UPPER_W = 6;

    // memory_write_control bit positions
    localparam int REGION_SELECT_BIT = 7;
    localparam int CONFIG_SPACE_SELECT_BIT = 6;
    localparam int ERASE_SELECT_BIT = 4;
    localparam int WRITE_ENABLE_BIT = 2;
    localparam int WRITE_START_BIT = 1;

    // ------------------------------------------------------------
    // code memory map
    // ------------------------------------------------------------
    localparam logic [21:0] SMALL_TOP = 22'h001FFF;
    localparam logic [21:0] SMALL_BOOT_TOP = 22'h0001FF;
    localparam int SMALL_BLK_LSB = 12;
    localparam logic [21:0] BIG_TOP = 22'h007FFF;
    localparam logic [21:0] BIG_BOOT_TOP = 22'h0007FF;
    localparam int BIG_BLK_LSB = 13;

    // protection units
    localparam int NUNITS = 8;
    localparam int U_BOOT = 0;
    localparam int U_BLK0 = 1;
    localparam int U_DATA = 5;
    localparam int U_CFG = 6;
    localparam int U_ID = 7;

    // ------------------------------------------------------------
    // bulk erase control
    // ------------------------------------------------------------
    localparam logic [21:0] BULK_ERASE_CTRL_LOW = 22'h3C0004;
    localparam logic [21:0] BULK_ERASE_CTRL_HIGH = 22'h3C0005;
    localparam logic [15:0] ER_CHIP = 16'h0F8F;
    localparam logic [15:0] ER_USER_ID = 16'h0088;
    localparam logic [15:0] ER_DATA = 16'h0084;
    localparam logic [15:0] ER_BOOT = 16'h0081;
    localparam logic [15:0] ER_CFG = 16'h0082;
    localparam logic [15:0] ER_BLK0 = 16'h0180;
    localparam logic [15:0] ER_BLK1 = 16'h0280;
    localparam logic [15:0] ER_BLK2 = 16'h0480;
    localparam logic [15:0] ER_BLK3 = 16'h0880;

    // ------------------------------------------------------------
    // host register map
    // ------------------------------------------------------------
    localparam logic [7:0] HREG_CMD = 8'h00;
    localparam logic [7:0] HREG_STATUS = 8'h04;
    localparam int HCMD_HOLD_BIT = 20;
    localparam int HST_BUSY_BIT = 0;
    localparam int HST_OVR_BIT = 1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int LINK_PERIOD_NS = 320;
    localparam int LINK_HALF_CYC =
        (LINK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BULK_ERASE_DURATION_US = 5000;
    localparam int ERASE_CYC =
        BULK_ERASE_DURATION_US * 1000 / CLK_PERIOD_NS;
    localparam int HOLD_CYC = ERASE_CYC + ERASE_CYC / 8;
endpackage : spb_pkg

/* test/serial_program_bulk_erase_tb_top.sv */
/* Bench: host end drives device end over spb_link_if.
   Assumes 25 MHz ref_clk and shortened erase and hold counts. */
module serial_program_bulk_erase_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, mwr, busy;
    logic [7:0] addr = 8'h00, pset = 8'h00, prot, emsk;
    logic pst, rer;
    logic [15:0] mwd;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [21:0] maddr;
    logic [15:0] codes[9] = '{16'h0F8F, 16'h0088, 16'h0084, 16'h0081,
        16'h0082, 16'h0180, 16'h0280, 16'h0480, 16'h0880};
    logic [7:0] lefts[9] = '{8'h00, 8'h7F, 8'hDF, 8'hFE, 8'hBF, 8'hFD,
        8'hFB, 8'hF7, 8'hEF};
    int n_errors = 0, checked = 0, cyc = 0, nwr = 0, nbz = 0;
    int npg = 0, nre = 0;
    spb_link_if lk();
    spb_host_end #(.HOLD_CYC(400)) u_spb_host_end (.ref_clk(ref_clk),
        .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .lk(lk.host));
    spb_dev_end #(.ERASE_CYC(300)) u_spb_dev_end (.ref_clk(ref_clk),
        .rst(rst), .lk(lk.dev), .protect_set(pset), .mem_wr(mwr),
        .mem_addr(maddr), .mem_wdata(mwd), .row_erase(rer),
        .prog_start(pst), .erase_busy(busy), .erase_mask(emsk),
        .protect(prot));
    spb_link_sva u_spb_link_sva (.ref_clk(ref_clk), .rst(rst),
        .sclk(lk.sclk), .host_dat_o(lk.host_dat_o), .dat(lk.dat),
        .host_dat_oe(lk.host_dat_oe), .dev_dat_oe(lk.dev_dat_oe));
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        nwr += mwr;
        nbz += busy;
        npg += pst;
        nre += rer;
        if (cyc == 60000) begin
            n_errors++;
            give_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'h0;
        rd <= 1'h0;
        #1 rv = rdata;
        @(posedge ref_clk);
    endtask
    task automatic frame(input logic [3:0] c, input logic [15:0] p,
                         input logic h = 1'h0);
        bus(1'h1, spb_pkg::HREG_CMD, {11'h0, h, p, c});
        rv = 32'h1;
        while (rv[0] !== 1'h0) bus(1'h0, spb_pkg::HREG_STATUS, 32'h0);
        // let the last frame's pulses be counted before any check
        @(posedge ref_clk);
    endtask
    task automatic ptr(input logic [21:0] a);
        frame(4'h0, {10'h038, a[21:16]});
        frame(4'h0, 16'h6EF8);
        frame(4'h0, {8'h0E, a[15:8]});
        frame(4'h0, 16'h6EF7);
        frame(4'h0, {8'h0E, a[7:0]});
        frame(4'h0, 16'h6EF6);
    endtask
    task automatic erase(input logic [15:0] code, input logic [7:0] left);
        int b;
        pset <= 8'hFF;
        @(posedge ref_clk);
        pset <= 8'h00;
        ptr(22'h3C0005);
        frame(4'hC, {2{code[15:8]}});
        ptr(22'h3C0004);
        frame(4'hC, {2{code[7:0]}});
        b = nbz;
        frame(4'h0, 16'h0000, 1'h1);
        chk(nbz - b, 300);
        chk(prot, left);
        chk({24'h0, emsk}, {24'h0, ~left});
    endtask
    task automatic s_table;
        int b;
        bus(1'h0, 8'h08, 32'h0);
        chk(rv, 32'h0);
        ptr(22'h000100);
        b = nwr;
        frame(4'hC, 16'h1234);
        chk(nwr - b, 0);
        frame(4'h0, 16'h8EA6);
        frame(4'h0, 16'h9CA6);
        frame(4'h0, 16'h84A6);
        frame(4'hD, 16'h1234);
        frame(4'hD, 16'h5678);
        chk(nwr - b, 2);
        chk(maddr, 22'h000102);
        chk(mwd, 16'h5678);
        frame(4'h0, 16'h82A6);
        frame(4'h0, 16'h88A6);
        frame(4'h0, 16'h82A6);
        frame(4'h0, 16'h94A6);
        frame(4'h0, 16'h82A6);
        chk(npg, 1);
        chk(nre, 1);
    endtask
    task automatic give_verdict;
        $display("errors=%0d checks=%0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'h0;
        repeat (8) @(posedge ref_clk);
        s_table();
        for (int k = 0; k < 9; k++) erase(codes[k], lefts[k]);
        give_verdict();
    end
endmodule // serial_program_bulk_erase_tb_top

/* test/spb_link_sva.sv */
/* Checks on the serial link wires between the two ends.
   Assumes the bench instantiates it beside spb_link_if. */
module spb_link_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic host_dat_o,
    input wire logic host_dat_oe,
    input wire logic dev_dat_oe,
    input wire logic dat
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [2:0] lo_r;
    logic [4:0] n_r;
    // low-time and rises-per-frame counters
    always_ff @(posedge ref_clk) begin
        lo_r <= (rst || sclk) ? 3'h0 : lo_r + {2'h0, lo_r != 3'h7};
        n_r <= (rst || lo_r == 3'h6) ? 5'h0 : n_r + {4'h0, $rose(sclk)};
    end
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
        else $error("sclk high time wrong");
    AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk[*4])
        else $error("sclk low time short");
    AST_DAT_HOLD: assert property ($fell(sclk) |-> $stable(host_dat_o))
        else $error("data moved at sample");
    AST_DAT_MOVE: assert property ($changed(host_dat_o) |->
        $rose(sclk) || lo_r >= 3'h2) else $error("data moved");
    AST_OWNER: assert property (host_dat_oe && !dev_dat_oe)
        else $error("wrong data driver");
    AST_LINE: assert property (dat == host_dat_o)
        else $error("line level wrong");
    AST_IDLE_LOW: assert property (lo_r == 3'h7 && !sclk |-> !dat)
        else $error("data high while idle");
    AST_FRAME_LEN: assert property (lo_r == 3'h5 |-> n_r inside
        {5'h0, 5'h14}) else $error("frame length wrong");
    cover property (lo_r == 3'h5 && n_r == 5'h14);
    cover property (lo_r == 3'h7);
    cover property ($fell(sclk));
endmodule // spb_link_sva
